//--- verilog/ssfs_pkg.sv
// Purpose: shared constants and types for the sync serial frame sequencer peer
// Assumes: 125 MHz clock; half-duplex master clock made by a divider
// Notes: register map below is the peer's own command/status window
package ssfs_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // master-mode serial clock period, in ns
   localparam int unsigned MST_PERIOD_NS = 64;
   // half period in cycles, rounded down, never below one
   localparam int unsigned MST_HALF_RAW = (MST_PERIOD_NS * CLK_MHZ) / 2000;
   localparam logic [7:0] MST_HALF = 8'((MST_HALF_RAW < 1) ? 1 : MST_HALF_RAW);
   // frame-select setup before the first sampling rise, in serial periods
   localparam int unsigned MST_SETUP_PERIODS = 2;
   localparam logic [1:0] MST_SETUP_RISES = 2'(MST_SETUP_PERIODS);
   localparam logic [7:0] MST_SETUP_CYC = 8'(MST_SETUP_PERIODS * 2 * MST_HALF_RAW);
   localparam logic [7:0] LOW_CNT_MAX = 8'hff;
   // control word is always eight bits
   localparam logic [2:0] HD_CTRL_LAST = 3'h7;
   localparam logic [3:0] IDX_FIRST = 4'h0;
   localparam logic [15:0] LEN_MASK_BASE = 16'hfffe;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TXW = 8'h04;
   localparam logic [7:0] ADDR_RXW = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;

   localparam logic [15:0] CTRL_RST = 16'h7700;
   localparam logic [15:0] CTRL_WMASK = 16'hff1f;
   localparam logic [15:0] TXW_RST = 16'h0000;
   localparam logic [15:0] RXW_RST = 16'h0000;
   localparam int unsigned STAT_RXV = 0;
   localparam int unsigned STAT_OVR = 1;
   localparam int unsigned STAT_BUSY = 2;
   localparam int unsigned STAT_FSS = 3;
   localparam int unsigned CMD_GO = 0;
   localparam logic [2:0] SYNC_INIT = 3'h2;

   // control register layout, low bit first from the right
   typedef struct packed {
      logic [3:0] rlen;
      logic [3:0] wlen;
      logic [2:0] rsvd;
      logic mst;
      logic hdx;
      logic pha;
      logic pol;
      logic en;
   } ssfs_cfg_t;

   // synchronised link lines
   typedef struct packed {
      logic clk;
      logic fss;
      logic tx;
   } ssfs_pins_t;

   typedef enum logic [2:0] {HD_IDLE, HD_CTRL, HD_WAIT, HD_RESP, HD_TAIL} ssfs_hd_t;
   typedef enum logic [2:0] {M_IDLE, M_ARM, M_SETUP, M_CTRL, M_WAIT, M_RESP, M_END} ssfs_ms_t;
endpackage : ssfs_pkg

//--- verilog/ssfs_sync.sv
// Purpose: two-flop synchroniser for link pins
// Assumes: inputs asynchronous to clock
// Notes: first stage is read only by the second
module ssfs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= INIT;
         dout <= INIT;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : ssfs_sync

//--- verilog/ssfs_edge.sv
// Purpose: rise and fall detector on a synchronised level
// Assumes: lvl already on the clock domain
// Notes: pulses are one cycle, combinational from the held level
module ssfs_edge (
   input wire logic clock,
   input wire logic rst,
   input wire logic lvl,
   output logic rise,
   output logic fall
);
   logic prev_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         // follow the level in reset so an idle-high pin shows no edge at release
         prev_q <= lvl;
      end else begin
         prev_q <= lvl;
      end
   end

   assign rise = lvl & ~prev_q;
   assign fall = ~lvl & prev_q;
endmodule : ssfs_edge

//--- verilog/ssfs_host.sv
// Purpose: off-chip peer of the sync serial port: slave in four clock modes,
//          half-duplex responder, and half-duplex master
// Assumes: link lines sampled by clock, serial clock far slower than clock
// Notes: rx line is the peer's only data output in every role
// How it works
// - phase zero: slave shows bit at select fall
// - mode 0/0: sample rising, change falling
// - mode 0/1: data at first rise, sample falling
// - mode 1/0: sample falling, change rising
// - mode 1/1: sample rising, change falling
// - responder waits one clock, returns 4-16 bits
// - select low all frame, rx quiet during control
// - control sampled rising, response driven falling
// - responder releases rx after LSB or select rise
// - master: select two and a half periods before first sample
module ssfs_host
   import ssfs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic serial_clock_line,
   output logic serial_clock_drv,
   output logic serial_clock_oe_n,
   input wire logic frame_select_line,
   output logic frame_select_drv,
   output logic frame_select_oe_n,
   input wire logic serial_tx_line,
   output logic serial_rx_drv,
   output logic serial_rx_oe_n
);
   ssfs_cfg_t cfg_q;
   logic [15:0] txw_q, rxw_q, rdata_q;
   logic rxv_q, ovr_q, go_q;
   ssfs_pins_t pins_s;
   logic lead_s, trail_s, fss_up, fss_dn;
   logic ev_lead, ev_trail;
   logic active_spi, active_hd, active_ms;
   logic [15:0] len_mask;
   // spi slave state
   logic [3:0] sp_idx_q, sp_cnt_q;
   logic [15:0] sp_sh_q;
   logic sp_out_q, sp_drv_q, sp_done;
   // half-duplex responder state
   ssfs_hd_t hd_q;
   logic [2:0] hd_cnt_q;
   logic [3:0] hd_idx_q;
   logic [7:0] hd_sh_q;
   logic hd_out_q, hd_drv_q, hd_done;
   // half-duplex master state
   ssfs_ms_t ms_q;
   logic [7:0] div_q, ms_low_q;
   logic sclk_q, fss_q, m_tick, m_rise, m_fall;
   logic [1:0] ms_rise_q;
   logic [3:0] ms_idx_q;
   logic [15:0] ms_sh_q;
   logic ms_out_q, ms_drv_q, ms_done;
   logic done_any, rd_rxw;
   logic [15:0] done_word;

   ssfs_sync #(.W(3), .INIT(SYNC_INIT)) u_sync (
      .clock(clock),
      .rst(rst),
      .din({serial_clock_line, frame_select_line, serial_tx_line}),
      .dout(pins_s)
   );

   // normalise polarity so lead is the move away from the rest level
   ssfs_edge u_ck (
      .clock(clock),
      .rst(rst),
      .lvl(pins_s.clk ^ (cfg_q.pol & ~cfg_q.hdx)),
      .rise(lead_s),
      .fall(trail_s)
   );

   ssfs_edge u_fs (
      .clock(clock),
      .rst(rst),
      .lvl(pins_s.fss),
      .rise(fss_up),
      .fall(fss_dn)
   );

   assign active_spi = cfg_q.en & ~cfg_q.mst & ~cfg_q.hdx;
   assign active_hd = cfg_q.en & ~cfg_q.mst & cfg_q.hdx;
   assign active_ms = cfg_q.en & cfg_q.mst;
   assign ev_lead = lead_s;
   assign ev_trail = trail_s;
   assign len_mask = ~(LEN_MASK_BASE << cfg_q.wlen);

   // software window
   assign rd_rxw = rd && (addr == ADDR_RXW);

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q <= ssfs_cfg_t'(CTRL_RST);
         txw_q <= TXW_RST;
         go_q <= 1'b0;
      end else begin
         go_q <= wr && (addr == ADDR_CMD) && wdata[CMD_GO];
         if (wr && addr == ADDR_CTRL) begin
            cfg_q <= ssfs_cfg_t'(wdata & CTRL_WMASK);
         end
         if (wr && addr == ADDR_TXW) begin
            txw_q <= wdata;
         end
      end
   end

   assign done_any = sp_done | hd_done | ms_done;
   assign done_word = sp_done ? ({sp_sh_q[14:0], pins_s.tx} & len_mask) :
                      hd_done ? {8'h00, hd_sh_q[6:0], pins_s.tx} :
                      ({ms_sh_q[14:0], pins_s.tx} & ~(LEN_MASK_BASE << cfg_q.rlen));

   // a word landing in the cycle of the clearing read still sets valid
   always_ff @(posedge clock) begin
      if (rst) begin
         rxw_q <= RXW_RST;
         rxv_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         if (done_any) begin
            rxw_q <= done_word;
            rxv_q <= 1'b1;
         end else if (rd_rxw) begin
            rxv_q <= 1'b0;
         end
         if (done_any && rxv_q && !rd_rxw) begin
            ovr_q <= 1'b1;
         end else if (wr && addr == ADDR_STAT && wdata[STAT_OVR]) begin
            ovr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            ADDR_CTRL: rdata_q <= 16'(cfg_q);
            ADDR_TXW: rdata_q <= txw_q;
            ADDR_RXW: rdata_q <= rxw_q;
            ADDR_STAT: rdata_q <= {12'h000, pins_s.fss, (ms_q != M_IDLE) | go_q, ovr_q, rxv_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end
   assign rdata = rdata_q;

   // spi-style slave: the port is master, pins sampled through the synchroniser
   always_ff @(posedge clock) begin
      if (rst || !active_spi || fss_up) begin
         sp_idx_q <= IDX_FIRST;
         sp_cnt_q <= IDX_FIRST;
         sp_sh_q <= 16'h0000;
         sp_out_q <= 1'b0;
         sp_drv_q <= 1'b0;
      end else if (fss_dn) begin
         // a new select fall reloads the word, so phase zero needs the pulse
         sp_idx_q <= cfg_q.wlen;
         sp_cnt_q <= IDX_FIRST;
         sp_drv_q <= 1'b1;
         sp_out_q <= cfg_q.pha ? 1'b0 : txw_q[cfg_q.wlen];
      end else if (!pins_s.fss) begin
         if (ev_lead) begin
            if (!cfg_q.pha) begin
               sp_sh_q <= {sp_sh_q[14:0], pins_s.tx};
               sp_cnt_q <= (sp_cnt_q == cfg_q.wlen) ? IDX_FIRST : sp_cnt_q + 4'h1;
            end else begin
               sp_out_q <= txw_q[sp_idx_q];
            end
         end else if (ev_trail) begin
            if (!cfg_q.pha) begin
               if (sp_idx_q != IDX_FIRST) begin
                  sp_idx_q <= sp_idx_q - 4'h1;
                  sp_out_q <= txw_q[sp_idx_q - 4'h1];
               end
            end else begin
               sp_sh_q <= {sp_sh_q[14:0], pins_s.tx};
               sp_cnt_q <= (sp_cnt_q == cfg_q.wlen) ? IDX_FIRST : sp_cnt_q + 4'h1;
               // select held low: next word starts straight after the last
               sp_idx_q <= (sp_idx_q == IDX_FIRST) ? cfg_q.wlen : sp_idx_q - 4'h1;
            end
         end
      end
   end
   assign sp_done = active_spi && !pins_s.fss && !fss_dn && !fss_up &&
                    (cfg_q.pha ? ev_trail : ev_lead) && (sp_cnt_q == cfg_q.wlen);

   // half-duplex responder
   always_ff @(posedge clock) begin
      if (rst || !active_hd || fss_up) begin
         hd_q <= HD_IDLE;
         hd_cnt_q <= 3'h0;
         hd_idx_q <= IDX_FIRST;
         hd_sh_q <= 8'h00;
         hd_out_q <= 1'b0;
         hd_drv_q <= 1'b0;
      end else begin
         unique case (hd_q)
            HD_IDLE: begin
               if (fss_dn) begin
                  hd_q <= HD_CTRL;
                  hd_cnt_q <= 3'h0;
               end
            end
            HD_CTRL: begin
               // rx stays released while the control word arrives
               if (ev_lead) begin
                  hd_sh_q <= {hd_sh_q[6:0], pins_s.tx};
                  hd_cnt_q <= hd_cnt_q + 3'h1;
                  if (hd_cnt_q == HD_CTRL_LAST) begin
                     hd_q <= HD_WAIT;
                  end
               end
            end
            HD_WAIT: begin
               if (ev_lead) begin
                  hd_q <= HD_RESP;
                  hd_idx_q <= cfg_q.rlen;
               end
            end
            HD_RESP: begin
               if (ev_trail) begin
                  hd_out_q <= txw_q[hd_idx_q];
                  hd_drv_q <= 1'b1;
               end else if (ev_lead) begin
                  if (hd_idx_q == IDX_FIRST) begin
                     hd_q <= HD_TAIL;
                  end else begin
                     hd_idx_q <= hd_idx_q - 4'h1;
                  end
               end
            end
            HD_TAIL: begin
               if (ev_trail) begin
                  hd_drv_q <= 1'b0;
                  hd_out_q <= 1'b0;
                  hd_q <= HD_CTRL;
                  hd_cnt_q <= 3'h0;
               end
            end
         endcase
      end
   end
   assign hd_done = active_hd && !fss_up && (hd_q == HD_CTRL) && ev_lead &&
                    (hd_cnt_q == HD_CTRL_LAST);

   // master clock divider, free running while master, rests low otherwise
   assign m_tick = active_ms && (div_q == MST_HALF - 8'h01);
   assign m_rise = m_tick & ~sclk_q;
   assign m_fall = m_tick & sclk_q;

   always_ff @(posedge clock) begin
      if (rst || !active_ms) begin
         div_q <= 8'h00;
         sclk_q <= 1'b0;
      end else if (m_tick) begin
         div_q <= 8'h00;
         sclk_q <= ~sclk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // half-duplex master; the port is the slave
   always_ff @(posedge clock) begin
      if (rst || !active_ms) begin
         ms_q <= M_IDLE;
         fss_q <= 1'b1;
         ms_rise_q <= 2'h0;
         ms_idx_q <= IDX_FIRST;
         ms_sh_q <= 16'h0000;
         ms_out_q <= 1'b0;
         ms_drv_q <= 1'b0;
      end else begin
         unique case (ms_q)
            M_IDLE: begin
               if (go_q) begin
                  ms_q <= M_ARM;
               end
            end
            M_ARM: begin
               if (m_fall) begin
                  fss_q <= 1'b0;
                  ms_rise_q <= 2'h0;
                  ms_q <= M_SETUP;
               end
            end
            M_SETUP: begin
               // skip two rises so select leads the first sample by two and a half periods
               if (m_rise) begin
                  ms_rise_q <= ms_rise_q + 2'h1;
                  if (ms_rise_q == MST_SETUP_RISES - 2'h1) begin
                     ms_q <= M_CTRL;
                     ms_idx_q <= {1'b0, HD_CTRL_LAST};
                  end
               end
            end
            M_CTRL: begin
               if (m_fall) begin
                  ms_out_q <= txw_q[ms_idx_q];
                  ms_drv_q <= 1'b1;
               end else if (m_rise) begin
                  if (ms_idx_q == IDX_FIRST) begin
                     ms_q <= M_WAIT;
                  end else begin
                     ms_idx_q <= ms_idx_q - 4'h1;
                  end
               end
            end
            M_WAIT: begin
               if (m_fall) begin
                  ms_drv_q <= 1'b0;
                  ms_out_q <= 1'b0;
               end else if (m_rise) begin
                  ms_q <= M_RESP;
                  ms_idx_q <= cfg_q.rlen;
               end
            end
            M_RESP: begin
               if (m_rise) begin
                  ms_sh_q <= {ms_sh_q[14:0], pins_s.tx};
                  if (ms_idx_q == IDX_FIRST) begin
                     ms_q <= M_END;
                  end else begin
                     ms_idx_q <= ms_idx_q - 4'h1;
                  end
               end
            end
            M_END: begin
               if (m_rise) begin
                  fss_q <= 1'b1;
                  ms_q <= M_IDLE;
               end
            end
         endcase
      end
   end
   assign ms_done = active_ms && (ms_q == M_RESP) && m_rise && (ms_idx_q == IDX_FIRST);

   // cycles since the master dropped select, for the setup check
   always_ff @(posedge clock) begin
      if (rst || fss_q) begin
         ms_low_q <= 8'h00;
      end else if (ms_low_q != LOW_CNT_MAX) begin
         ms_low_q <= ms_low_q + 8'h01;
      end
   end

   // pins: clock and select only driven in master role
   assign serial_clock_drv = sclk_q;
   assign serial_clock_oe_n = ~active_ms;
   assign frame_select_drv = fss_q;
   assign frame_select_oe_n = ~active_ms;
   assign serial_rx_drv = active_ms ? ms_out_q : (active_hd ? hd_out_q : sp_out_q);
   assign serial_rx_oe_n = active_ms ? ~ms_drv_q : (active_hd ? ~hd_drv_q : ~sp_drv_q);

   // checks
   logic msb_now, bit_now;
   assign msb_now = txw_q[cfg_q.wlen];
   assign bit_now = txw_q[sp_idx_q];

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   pha0_first_a: assert property (
      active_spi && !cfg_q.pha && fss_dn && !fss_up |=> sp_drv_q && sp_out_q == $past(msb_now))
      else $error("phase zero slave bit not shown at select fall");
   pha0_sample_a: assert property (
      active_spi && !cfg_q.pha && !pins_s.fss && ev_lead && !fss_dn && !fss_up
      |=> sp_sh_q[0] == $past(pins_s.tx))
      else $error("phase zero did not sample on leading edge");
   pha0_change_a: assert property (
      active_spi && !cfg_q.pha && !pins_s.fss && ev_trail && sp_idx_q != IDX_FIRST
      && !fss_dn && !fss_up |=> sp_idx_q == $past(sp_idx_q) - 4'h1)
      else $error("phase zero did not advance on trailing edge");
   pha1_launch_a: assert property (
      active_spi && cfg_q.pha && !pins_s.fss && ev_lead && !fss_dn && !fss_up
      |=> sp_out_q == $past(bit_now))
      else $error("phase one did not launch on leading edge");
   pha1_hold_a: assert property (
      active_spi && cfg_q.pha && ev_trail && !fss_dn && !fss_up |=> $stable(sp_out_q))
      else $error("phase one output moved on sampling edge");
   hd_quiet_a: assert property (
      active_hd && hd_q == HD_CTRL |-> serial_rx_oe_n)
      else $error("rx driven during control word");
   hd_wait_a: assert property (
      active_hd && hd_q == HD_WAIT && ev_lead && !fss_up |=> hd_q == HD_RESP && !hd_drv_q)
      else $error("wait clock not exactly one");
   hd_resp_edge_a: assert property (
      active_hd && $past(hd_q) == HD_RESP && $changed(hd_out_q) |-> $past(ev_trail))
      else $error("response bit changed off falling edge");
   hd_release_a: assert property (
      active_hd && hd_q == HD_TAIL && ev_trail && !fss_up |=> serial_rx_oe_n && hd_q == HD_CTRL)
      else $error("rx not released after response lsb");
   ms_setup_a: assert property (
      active_ms && ms_q == M_CTRL && m_rise |-> ms_low_q >= MST_SETUP_CYC)
      else $error("select setup before first sample too short");

   spi_word_c: cover property (sp_done && !cfg_q.pha);
   spi_cont_c: cover property (sp_done && cfg_q.pha ##[1:200] sp_done);
   hd_frame_c: cover property (active_hd && hd_q == HD_TAIL && ev_trail);
   ms_frame_c: cover property (ms_done);
endmodule : ssfs_host

//--- bench/ssfs_pm.sv
// Purpose: behavioural model of the sync serial port facing the peer
// Assumes: half serial period of four clocks, so a 64 ns link clock
// Notes: as slave it answers all ones for the whole frame
module ssfs_pm (
   input wire logic clock,
   input wire logic slave,
   input wire logic rx,
   input wire logic fss_in,
   output logic sclk,
   output logic clk_oe,
   output logic fss,
   output logic tx,
   output logic ctl
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 4;
   logic tx_q = 1'b0;
   logic [15:0] got = 16'h0000;
   assign tx = slave ? ~fss_in : tx_q;
   assign clk_oe = ~slave;
   initial begin
      sclk = 1'b0;
      fss = 1'b1;
      ctl = 1'b0;
   end
   task automatic hw();
      repeat (HALF) @(posedge clock);
   endtask : hw
   task automatic spi(input logic pol, input logic pha, input logic [15:0] w,
                      input int n, input int words);
      @(posedge clock);
      sclk <= pol;
      // let the rest level settle before select falls
      hw();
      for (int k = 0; k < words; k++) begin
         got = 16'h0000;
         fss <= 1'b0;
         // phase one runs straight on into the next word
         if (!pha || k == 0) hw();
         if (!pha) begin
            tx_q <= w[n-1];
            hw();
         end
         for (int i = n - 1; i >= 0; i--) begin
            sclk <= ~pol;
            if (pha) tx_q <= w[i];
            else got = {got[14:0], rx};
            hw();
            sclk <= pol;
            if (pha) got = {got[14:0], rx};
            else if (i > 0) tx_q <= w[i-1];
            hw();
         end
         // phase one keeps select low, so the peer wraps to its next word
         if (!pha || k == words - 1) begin
            // one period after the last capture edge
            if (pha) hw();
            fss <= 1'b1;
            tx_q <= 1'b0;
            hw();
            hw();
         end
      end
   endtask : spi
   task automatic hd(input logic [7:0] c, input int r, input int frames);
      @(posedge clock);
      sclk <= 1'b0;
      hw();
      for (int k = 0; k < frames; k++) begin
         got = 16'h0000;
         fss <= 1'b0;
         for (int i = 7; i >= 0; i--) begin
            tx_q <= c[i];
            hw();
            sclk <= 1'b1;
            ctl <= 1'b1;
            hw();
            sclk <= 1'b0;
         end
         ctl <= 1'b0;
         tx_q <= 1'b0;
         hw();
         sclk <= 1'b1;
         hw();
         sclk <= 1'b0;
         for (int i = 0; i < r; i++) begin
            hw();
            sclk <= 1'b1;
            got = {got[14:0], rx};
            hw();
            sclk <= 1'b0;
         end
      end
      hw();
      fss <= 1'b1;
      hw();
      hw();
   endtask : hd
endmodule : ssfs_pm

//--- bench/tb_top.sv
// Purpose: self-checking bench for the serial peer
// Assumes: port model masters the link except in the peer-master test
// Notes: released lines toggle every cycle since no pull is fitted
module tb_top
   import ssfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slave_mode = 1'b0;
   logic rx_last = 1'b0;
   logic [15:0] rdata, v;
   logic h_clk, h_clk_oe_n, h_fss, h_fss_oe_n, h_rx, h_rx_oe_n;
   logic m_clk, m_clk_oe, m_fss, m_tx, m_ctl, clk_w, fss_w, rx_w;
   int failures = 0;
   int comparisons = 0;
   always #4 clock = ~clock;
   assign rx_w = h_rx_oe_n ? ~rx_last : h_rx;
   assign clk_w = m_clk_oe ? m_clk : (h_clk_oe_n ? ~rx_last : h_clk);
   assign fss_w = m_clk_oe ? m_fss : (h_fss_oe_n ? ~rx_last : h_fss);
   always @(posedge clock) rx_last <= rx_w;
   ssfs_host i_ssfs_host (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_line(clk_w),
      .serial_clock_drv(h_clk), .serial_clock_oe_n(h_clk_oe_n),
      .frame_select_line(fss_w), .frame_select_drv(h_fss),
      .frame_select_oe_n(h_fss_oe_n), .serial_tx_line(m_tx),
      .serial_rx_drv(h_rx), .serial_rx_oe_n(h_rx_oe_n));
   ssfs_pm i_ssfs_pm (.clock(clock), .slave(slave_mode), .rx(rx_w), .fss_in(fss_w),
      .sclk(m_clk), .clk_oe(m_clk_oe), .fss(m_fss), .tx(m_tx), .ctl(m_ctl));
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   function automatic logic [15:0] low_mask(input int n);
      return 16'hffff >> (16 - n);
   endfunction : low_mask
   task automatic end_sim();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // the peer must keep off the rx line while the control byte goes out
   always @(posedge clock) if (m_ctl) check("rx released", {15'h0, h_rx_oe_n}, 16'h0001);
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      int n;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd_reg(ADDR_CTRL, v);
      check("ctrl reset", v, CTRL_RST);
      rd_reg(ADDR_STAT, v);
      check("status idle", v, 16'h0008);
      rd_reg(8'h14, v);
      check("unmapped read", v, 16'h0000);
      check("pads released", {14'h0000, h_clk_oe_n, h_fss_oe_n}, 16'h0003);
      // the four clock modes, word lengths at both ends of the range
      for (int m = 0; m < 4; m++) begin
         n = (m == 0) ? 16 : 4 * m;
         wr_reg(ADDR_CTRL, {4'h7, 4'(n - 1), 5'h00, m[0], m[1], 1'b1});
         wr_reg(ADDR_TXW, 16'h5a3c);
         i_ssfs_pm.spi(m[1], m[0], 16'hc3a5, n, 2);
         check("port got", i_ssfs_pm.got, 16'h5a3c & low_mask(n));
         rd_reg(ADDR_RXW, v);
         check("peer got", v, 16'hc3a5 & low_mask(n));
         rd_reg(ADDR_STAT, v);
         check("status overrun", v, 16'h000a);
         wr_reg(ADDR_STAT, 16'h0002);
      end
      // half-duplex with shortest and longest response, continuous first
      for (int r = 4; r <= 16; r += 12) begin
         wr_reg(ADDR_CTRL, {4'(r - 1), 4'h7, 8'h09});
         wr_reg(ADDR_TXW, 16'hb6d9);
         i_ssfs_pm.hd(8'ha7, r, 2 - r / 16);
         check("response", i_ssfs_pm.got, 16'hb6d9 & low_mask(r));
         rd_reg(ADDR_RXW, v);
         check("control byte", v, 16'h00a7);
      end
      slave_mode <= 1'b1;
      wr_reg(ADDR_CTRL, 16'h7719);
      wr_reg(ADDR_TXW, 16'h005c);
      check("pads driven", {14'h0000, h_clk_oe_n, h_fss_oe_n}, 16'h0000);
      wr_reg(ADDR_CMD, 16'h0001);
      rd_reg(ADDR_STAT, v);
      check("master busy", {15'h0, v[2]}, 16'h0001);
      for (int k = 0; k < 400 && v[2] !== 1'b0; k++) rd_reg(ADDR_STAT, v);
      check("master done", {15'h0, v[2]}, 16'h0000);
      check("select idle", {15'h0000, h_fss}, 16'h0001);
      rd_reg(ADDR_RXW, v);
      check("master rx", v, 16'h00ff);
      end_sim();
   end
endmodule : tb_top
